// ### rtl/fmrb_params.svh
`ifndef FMRB_PARAMS_SVH
`define FMRB_PARAMS_SVH
// register pointer values
`define FMRB_REG_STATUS 4'h0
`define FMRB_REG_FAULT 4'h1
`define FMRB_REG_ALERT 4'h2
`define FMRB_REG_CTRL 4'h3
`define FMRB_REG_SENSE_HI 4'h4
`define FMRB_REG_SENSE_LO 4'h5
`define FMRB_REG_SECOND_HI 4'h6
`define FMRB_REG_SECOND_LO 4'h7
`define FMRB_REG_AUX_HI 4'h8
`define FMRB_REG_AUX_LO 4'h9
`define FMRB_PTR_W 4
// bus address bytes, R/W bit included
`define FMRB_ADDR_BASE 8'h20
`define FMRB_ADDR_MASS 8'h3E
`define FMRB_ADDR_ARA 8'h19
`define FMRB_ADDR_BCAST_IDX 4'h8
// reset values
`define FMRB_FAULT_RST 8'h00
`define FMRB_ALERT_RST 8'h00
`define FMRB_CTRL_RST 8'h03
`define FMRB_PTR_RST 4'h0
// fault log / alert enable bit positions
`define FMRB_FLT_EXT 7
`define FMRB_FLT_GPI 6
`define FMRB_FLT_SHORT 5
`define FMRB_FLT_EN 4
`define FMRB_FLT_PBAD 3
`define FMRB_FLT_OC 2
`define FMRB_FLT_UV 1
`define FMRB_FLT_OV 0
`define FMRB_ALERT_GPO 6
`define FMRB_ALERT_EN_MASK 8'hBF
// status bit positions
`define FMRB_ST_FET 7
`define FMRB_ST_GPI 6
`define FMRB_ST_SHORT 5
`define FMRB_ST_EN 4
`define FMRB_ST_PBAD 3
`define FMRB_ST_OC 2
`define FMRB_ST_UV 1
`define FMRB_ST_OV 0
// control bit positions and pin-config field codes (bits 7:6)
`define FMRB_CTRL_CFG_HI 7
`define FMRB_CTRL_CFG_LO 6
`define FMRB_CTRL_TEST 5
`define FMRB_CTRL_FET 3
`define FMRB_CFG_GPO 2'h1
`define FMRB_CFG_GPI 2'h3
// adc layout
`define FMRB_ADC_W 10
`define FMRB_ADC_CH 3
`define FMRB_ADC_LO_PAD 6'h00
`define FMRB_ADC_FIRST 3'h2
`endif

// ### rtl/fmrb_pkg.sv
`include "fmrb_params.svh"
package fmrb_pkg;
  // three-state address pin level
  typedef enum logic [1:0] {FMRB_TRI_LOW, FMRB_TRI_OPEN, FMRB_TRI_HIGH} fmrb_tri_e;

  // byte events from the serial protocol engine
  typedef struct packed {
    logic addr_valid;
    logic [7:0] addr_byte;
    logic cmd_valid;
    logic [7:0] cmd;
    logic wr_valid;
    logic [7:0] wr_data;
    logic ara_sent;
    logic stop;
  } fmrb_bus_s;

  // live conditions from the analog side
  typedef struct packed {
    logic fet_on;
    logic en_pin;
    logic sense_over;
    logic power_good_check_input;
    logic pg_timer_done;
    logic overcurrent;
    logic upper_threshold_input;
    logic lower_threshold_input;
    logic high_line_input;
    logic external_fault_input_n;
    logic pg_pull_low;
  } fmrb_mon_s;

  // one finished conversion
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic [`FMRB_ADC_W-1:0] value;
  } fmrb_adc_s;

  typedef struct packed {
    logic [7:0] fault;
    logic [7:0] alert_en;
    logic [7:0] ctrl;
    logic [`FMRB_PTR_W-1:0] ptr;
    logic [`FMRB_ADC_CH-1:0][`FMRB_ADC_W-1:0] adc;
    logic [7:0] alerted;
    logic alert;
    logic alert_out;
    logic en_prev;
    logic en_seen;
    logic [7:0] own_addr;
    logic bcast;
    logic ara;
    logic addr_ack;
    logic [7:0] rd_data;
    logic gp_pin_out;
    logic gp_pin_oe;
  } fmrb_state_s;
endpackage

// ### rtl/fmrb_top.sv
// What this block does
// - decode slave address from three-state pins
// - ignore upper four pointer bits
// - adc registers writable only in test mode
// - adc value split msbs then two lsbs
// - status read-only, bit7 shows transistor on
// - status bit6 shows gp input level
// - status bit5 sense over while commanded off
// - status bit3 power bad after check timer
// - status bits 2..0 live oc, uv, ov
// - log gp input high and external fault
// - log shorted transistor condition
// - log any board-presence pin change
// - log power bad at timer end
// - log oc, uv, ov and keep set
// - host reads and overwrites fault log
// - alert enables per fault, reset zero
// - alert bit6 drives gp output, reset zero
// - alert low only for enabled logged fault
// - control register read/write, retry and on/off
// - command byte low nibble into sticky pointer
// - release alert when addressed, rearm on new
// - test mode halts conversions, reset zero
`timescale 1ns/10ps
`include "fmrb_params.svh"
module fmrb_top (
  input wire logic clk,
  input wire logic srst,
  input wire fmrb_pkg::fmrb_tri_e addr_select_pin_lo,
  input wire fmrb_pkg::fmrb_tri_e addr_select_pin_hi,
  input wire fmrb_pkg::fmrb_bus_s bus_in,
  input wire fmrb_pkg::fmrb_mon_s mon_in,
  input wire fmrb_pkg::fmrb_adc_s adc_in,
  input wire logic power_good_gp_pin_i,
  output logic power_good_gp_pin_o,
  output logic power_good_gp_pin_oe,
  output logic alert_o,
  output logic alert_oe,
  output logic addr_ack,
  output logic broadcast_mode,
  output logic [7:0] rd_data,
  output logic [7:0] control_out,
  output logic adc_halt
);
  import fmrb_pkg::*;

  fmrb_state_s q_r;
  fmrb_state_s q_nxt;

  // table lookup of the pin pair; index 8 means serial broadcast instead of the bus
  function automatic logic [3:0] addr_index(input fmrb_tri_e hi, input fmrb_tri_e lo);
    logic [3:0] idx;
    idx = 4'h0;
    unique case ({hi, lo})
      {FMRB_TRI_LOW, FMRB_TRI_LOW}: idx = 4'h0;
      {FMRB_TRI_LOW, FMRB_TRI_OPEN}: idx = 4'h1;
      {FMRB_TRI_HIGH, FMRB_TRI_OPEN}: idx = 4'h2;
      {FMRB_TRI_LOW, FMRB_TRI_HIGH}: idx = 4'h3;
      {FMRB_TRI_OPEN, FMRB_TRI_LOW}: idx = 4'h4;
      {FMRB_TRI_OPEN, FMRB_TRI_OPEN}: idx = 4'h5;
      {FMRB_TRI_HIGH, FMRB_TRI_HIGH}: idx = 4'h6;
      {FMRB_TRI_OPEN, FMRB_TRI_HIGH}: idx = 4'h7;
      {FMRB_TRI_HIGH, FMRB_TRI_LOW}: idx = `FMRB_ADDR_BCAST_IDX;
      default: idx = 4'h0;
    endcase
    return idx;
  endfunction

  // adc channel behind a pointer in the converter range
  function automatic logic [1:0] adc_chan(input logic [`FMRB_PTR_W-1:0] ptr);
    logic [2:0] c;
    c = ptr[3:1] - `FMRB_ADC_FIRST;
    return c[1:0];
  endfunction

  function automatic logic is_adc_reg(input logic [`FMRB_PTR_W-1:0] ptr);
    return (ptr >= `FMRB_REG_SENSE_HI) && (ptr <= `FMRB_REG_AUX_LO);
  endfunction

  logic [7:0] status;
  logic gpi_mode;
  logic gpo_mode;
  logic [7:0] fault_set;
  logic [3:0] idx;
  logic indiv_hit;
  logic mass_hit;
  logic ara_hit;
  logic host_wr;
  logic release_alert;
  logic [7:0] fw;
  logic [7:0] am;
  logic [7:0] pending;
  logic [1:0] ch;

  // live status, recomputed every cycle; nothing here is writable
  always_comb
  begin
    gpi_mode = q_r.ctrl[`FMRB_CTRL_CFG_HI:`FMRB_CTRL_CFG_LO] == `FMRB_CFG_GPI;
    gpo_mode = q_r.ctrl[`FMRB_CTRL_CFG_HI:`FMRB_CTRL_CFG_LO] == `FMRB_CFG_GPO;
    status = 8'h00;
    status[`FMRB_ST_FET] = mon_in.fet_on;
    status[`FMRB_ST_GPI] = gpi_mode & power_good_gp_pin_i;
    status[`FMRB_ST_SHORT] = mon_in.sense_over & ~q_r.ctrl[`FMRB_CTRL_FET];
    status[`FMRB_ST_EN] = mon_in.en_pin;
    status[`FMRB_ST_PBAD] = mon_in.power_good_check_input & mon_in.pg_timer_done;
    status[`FMRB_ST_OC] = mon_in.overcurrent;
    status[`FMRB_ST_UV] = ~mon_in.upper_threshold_input & ~mon_in.lower_threshold_input;
    status[`FMRB_ST_OV] = mon_in.high_line_input;
  end

  // read mux; unmapped pointers answer zero
  function automatic logic [7:0] rd_mux(input logic [`FMRB_PTR_W-1:0] ptr,
                                        input fmrb_state_s s, input logic [7:0] st);
    logic [7:0] d;
    logic [`FMRB_ADC_W-1:0] v;
    v = s.adc[adc_chan(ptr)];
    d = 8'h00;
    if (ptr == `FMRB_REG_STATUS)
      d = st;
    else if (ptr == `FMRB_REG_FAULT)
      d = s.fault;
    else if (ptr == `FMRB_REG_ALERT)
      d = s.alert_en;
    else if (ptr == `FMRB_REG_CTRL)
      d = s.ctrl;
    else if (is_adc_reg(ptr) && !ptr[0])
      d = v[`FMRB_ADC_W-1:2];
    else if (is_adc_reg(ptr))
      d = {v[1:0], `FMRB_ADC_LO_PAD};
    return d;
  endfunction

  // next-state logic: address decode, register writes, fault capture, alert arming
  always_comb
  begin
    q_nxt = q_r;
    idx = addr_index(addr_select_pin_hi, addr_select_pin_lo);
    q_nxt.bcast = idx == `FMRB_ADDR_BCAST_IDX;
    q_nxt.own_addr = `FMRB_ADDR_BASE | {4'h0, idx[2:0], 1'b0};
    // the bus is dead in broadcast mode, so nothing matches there
    indiv_hit = bus_in.addr_valid & ~q_r.bcast
                & ({bus_in.addr_byte[7:1], 1'b0} == q_r.own_addr);
    mass_hit = bus_in.addr_valid & ~q_r.bcast & (bus_in.addr_byte == `FMRB_ADDR_MASS);
    ara_hit = bus_in.addr_valid & ~q_r.bcast & (bus_in.addr_byte == `FMRB_ADDR_ARA)
              & q_r.alert;
    q_nxt.addr_ack = indiv_hit | mass_hit | ara_hit;
    if (bus_in.addr_valid)
      q_nxt.ara = ara_hit;
    else if (bus_in.stop)
      q_nxt.ara = 1'b0;
    // pointer survives stop so receive-byte can repeat reads
    if (bus_in.cmd_valid)
      q_nxt.ptr = bus_in.cmd[`FMRB_PTR_W-1:0];
    host_wr = bus_in.wr_valid & ~q_r.ara;
    // fault events are level-set; a host clear loses to a live event in the same cycle
    fault_set = 8'h00;
    fault_set[`FMRB_FLT_EXT] = ~mon_in.external_fault_input_n;
    fault_set[`FMRB_FLT_GPI] = gpi_mode & power_good_gp_pin_i;
    fault_set[`FMRB_FLT_SHORT] = status[`FMRB_ST_SHORT];
    fault_set[`FMRB_FLT_EN] = q_r.en_seen & (mon_in.en_pin != q_r.en_prev);
    fault_set[`FMRB_FLT_PBAD] = status[`FMRB_ST_PBAD];
    fault_set[`FMRB_FLT_OC] = status[`FMRB_ST_OC];
    fault_set[`FMRB_FLT_UV] = status[`FMRB_ST_UV];
    fault_set[`FMRB_FLT_OV] = status[`FMRB_ST_OV];
    q_nxt.en_prev = mon_in.en_pin;
    q_nxt.en_seen = 1'b1;
    fw = q_r.fault;
    ch = adc_chan(q_r.ptr);
    if (host_wr)
    begin
      if (q_r.ptr == `FMRB_REG_FAULT)
        fw = bus_in.wr_data;
      else if (q_r.ptr == `FMRB_REG_ALERT)
        q_nxt.alert_en = bus_in.wr_data;
      else if (q_r.ptr == `FMRB_REG_CTRL)
        q_nxt.ctrl = bus_in.wr_data;
      else if (is_adc_reg(q_r.ptr) && q_r.ctrl[`FMRB_CTRL_TEST] && !q_r.ptr[0])
        q_nxt.adc[ch][`FMRB_ADC_W-1:2] = bus_in.wr_data;
      else if (is_adc_reg(q_r.ptr) && q_r.ctrl[`FMRB_CTRL_TEST])
        q_nxt.adc[ch][1:0] = bus_in.wr_data[7:6];
    end
    q_nxt.fault = fw | fault_set;
    // test mode freezes conversion results so the host owns them
    if (adc_in.valid && !q_r.ctrl[`FMRB_CTRL_TEST] && adc_in.channel < 2'(`FMRB_ADC_CH))
      q_nxt.adc[adc_in.channel] = adc_in.value;
    // bits already alerted on are masked until the log bit is cleared and set again
    release_alert = indiv_hit | (bus_in.ara_sent & q_r.ara);
    am = q_r.alerted & q_nxt.fault;
    if (release_alert)
      am = am | (q_r.fault & q_r.alert_en & `FMRB_ALERT_EN_MASK);
    q_nxt.alerted = am;
    pending = q_nxt.fault & q_nxt.alert_en & `FMRB_ALERT_EN_MASK & ~am;
    q_nxt.alert = |pending;
    q_nxt.alert_out = 1'b0;
    // pin use chosen by control bits 7:6; open-drain power-good otherwise
    if (gpo_mode)
    begin
      q_nxt.gp_pin_out = q_r.alert_en[`FMRB_ALERT_GPO];
      q_nxt.gp_pin_oe = 1'b1;
    end
    else if (gpi_mode)
    begin
      q_nxt.gp_pin_out = 1'b0;
      q_nxt.gp_pin_oe = 1'b0;
    end
    else
    begin
      q_nxt.gp_pin_out = 1'b0;
      q_nxt.gp_pin_oe = mon_in.pg_pull_low;
    end
    // during alert response the byte sent back is our own address
    q_nxt.rd_data = q_nxt.ara ? q_nxt.own_addr : rd_mux(q_nxt.ptr, q_nxt, status);
  end

  // state register; synchronous reset to documented defaults
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q_r <= '0;
      q_r.fault <= `FMRB_FAULT_RST;
      q_r.alert_en <= `FMRB_ALERT_RST;
      q_r.ctrl <= `FMRB_CTRL_RST;
      q_r.ptr <= `FMRB_PTR_RST;
    end
    else
      q_r <= q_nxt;
  end

  // outputs straight from the state flops
  assign power_good_gp_pin_o = q_r.gp_pin_out;
  assign power_good_gp_pin_oe = q_r.gp_pin_oe;
  assign alert_o = q_r.alert_out;
  assign alert_oe = q_r.alert;
  assign addr_ack = q_r.addr_ack;
  assign broadcast_mode = q_r.bcast;
  assign rd_data = q_r.rd_data;
  assign control_out = q_r.ctrl;
  assign adc_halt = q_r.ctrl[`FMRB_CTRL_TEST];

  // checks
  // address decode and pointer handling
  a_mass_ack: assert property (@(posedge clk) disable iff (srst)
    bus_in.addr_valid && bus_in.addr_byte == `FMRB_ADDR_MASS && !q_r.bcast |=> addr_ack)
    else $error("mass write address not acknowledged");

  a_bcast_noack: assert property (@(posedge clk) disable iff (srst)
    q_r.bcast && q_nxt.bcast |=> !addr_ack)
    else $error("acknowledge given in broadcast mode");

  a_bcast_decode: assert property (@(posedge clk) disable iff (srst)
    addr_select_pin_hi == FMRB_TRI_HIGH && addr_select_pin_lo == FMRB_TRI_LOW
    |=> broadcast_mode)
    else $error("broadcast pins did not select broadcast mode");

  a_ptr_nibble: assert property (@(posedge clk) disable iff (srst)
    bus_in.cmd_valid |=> q_r.ptr == $past(bus_in.cmd[3:0]))
    else $error("pointer not loaded from command low nibble");

  a_ptr_sticky: assert property (@(posedge clk) disable iff (srst)
    bus_in.stop && !bus_in.cmd_valid |=> $stable(q_r.ptr))
    else $error("pointer changed at stop");

  // writes land where the pointer says, and only there
  a_ctrl_write: assert property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && !q_r.ara && q_r.ptr == `FMRB_REG_CTRL
    |=> control_out == $past(bus_in.wr_data))
    else $error("control write lost");

  a_alert_en_write: assert property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && !q_r.ara && q_r.ptr == `FMRB_REG_ALERT
    |=> q_r.alert_en == $past(bus_in.wr_data))
    else $error("alert enable write lost");

  a_fault_write: assert property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && !q_r.ara && q_r.ptr == `FMRB_REG_FAULT
    |=> q_r.fault == ($past(bus_in.wr_data) | $past(fault_set)))
    else $error("fault log write wrong");

  a_wr_ignored: assert property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && (q_r.ptr == `FMRB_REG_STATUS || q_r.ptr > `FMRB_REG_AUX_LO)
    |=> $stable(control_out) && $stable(q_r.alert_en))
    else $error("write to read-only or unmapped register took effect");

  // converter results
  a_adc_ro: assert property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && !q_r.ctrl[`FMRB_CTRL_TEST] && !adc_in.valid |=> $stable(q_r.adc))
    else $error("adc register changed outside test mode");

  a_adc_test_wr: assert property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && !q_r.ara && q_r.ctrl[`FMRB_CTRL_TEST] && is_adc_reg(q_r.ptr)
    && !q_r.ptr[0] |=> rd_data == $past(bus_in.wr_data))
    else $error("test mode adc write not read back");

  a_adc_lo_pad: assert property (@(posedge clk) disable iff (srst)
    is_adc_reg(q_nxt.ptr) && q_nxt.ptr[0] && !q_nxt.ara
    |=> rd_data[5:0] == `FMRB_ADC_LO_PAD)
    else $error("adc low byte padding not zero");

  a_halt_freeze: assert property (@(posedge clk) disable iff (srst)
    adc_in.valid && q_r.ctrl[`FMRB_CTRL_TEST] && !bus_in.wr_valid |=> $stable(q_r.adc))
    else $error("conversion result taken in test mode");

  // live status follows its inputs one cycle later
  a_status_read: assert property (@(posedge clk) disable iff (srst)
    q_nxt.ptr == `FMRB_REG_STATUS && !q_nxt.ara |=> rd_data[`FMRB_ST_FET] == $past(mon_in.fet_on))
    else $error("status transistor bit wrong");

  a_status_gpi: assert property (@(posedge clk) disable iff (srst)
    q_nxt.ptr == `FMRB_REG_STATUS && !q_nxt.ara
    |=> rd_data[`FMRB_ST_GPI] == $past(gpi_mode && power_good_gp_pin_i))
    else $error("status input pin bit wrong");

  a_status_short: assert property (@(posedge clk) disable iff (srst)
    q_nxt.ptr == `FMRB_REG_STATUS && !q_nxt.ara
    |=> rd_data[`FMRB_ST_SHORT] == $past(mon_in.sense_over && !q_r.ctrl[`FMRB_CTRL_FET]))
    else $error("status short bit wrong");

  a_status_pbad: assert property (@(posedge clk) disable iff (srst)
    q_nxt.ptr == `FMRB_REG_STATUS && !q_nxt.ara
    |=> rd_data[`FMRB_ST_PBAD]
        == $past(mon_in.power_good_check_input && mon_in.pg_timer_done))
    else $error("status power bad bit wrong");

  a_status_uv: assert property (@(posedge clk) disable iff (srst)
    q_nxt.ptr == `FMRB_REG_STATUS && !q_nxt.ara
    |=> rd_data[`FMRB_ST_UV]
        == $past(!mon_in.upper_threshold_input && !mon_in.lower_threshold_input))
    else $error("status undervoltage bit wrong");

  // log bits latch and stay until the host overwrites them
  a_fault_sticky: assert property (@(posedge clk) disable iff (srst)
    mon_in.overcurrent ##1 !(bus_in.wr_valid && q_r.ptr == `FMRB_REG_FAULT)[*2]
    |-> q_r.fault[`FMRB_FLT_OC])
    else $error("overcurrent log bit lost");

  a_en_change: assert property (@(posedge clk) disable iff (srst)
    q_r.en_seen && $changed(mon_in.en_pin) |=> q_r.fault[`FMRB_FLT_EN])
    else $error("presence change not logged");

  a_ext_log: assert property (@(posedge clk) disable iff (srst)
    !mon_in.external_fault_input_n |=> q_r.fault[`FMRB_FLT_EXT])
    else $error("external fault not logged");

  a_short_log: assert property (@(posedge clk) disable iff (srst)
    mon_in.sense_over && !q_r.ctrl[`FMRB_CTRL_FET] |=> q_r.fault[`FMRB_FLT_SHORT])
    else $error("shorted transistor not logged");

  a_pbad_log: assert property (@(posedge clk) disable iff (srst)
    mon_in.power_good_check_input && mon_in.pg_timer_done |=> q_r.fault[`FMRB_FLT_PBAD])
    else $error("power bad not logged");

  // alert pull follows enabled log bits not yet reported
  a_alert_cause: assert property (@(posedge clk) disable iff (srst)
    alert_oe |-> |(q_r.fault & q_r.alert_en & `FMRB_ALERT_EN_MASK))
    else $error("alert without enabled logged fault");

  a_alert_release: assert property (@(posedge clk) disable iff (srst)
    alert_oe && bus_in.addr_valid && !q_r.bcast && fault_set == 8'h00
    && {bus_in.addr_byte[7:1], 1'b0} == q_r.own_addr |=> !alert_oe)
    else $error("alert not released when addressed");

  // general-purpose pin drive and unmapped register reads
  a_gpo_drive: assert property (@(posedge clk) disable iff (srst)
    gpo_mode |=> power_good_gp_pin_oe
    && power_good_gp_pin_o == $past(q_r.alert_en[`FMRB_ALERT_GPO]))
    else $error("general-purpose output not driven");

  a_undef_zero: assert property (@(posedge clk) disable iff (srst)
    q_nxt.ptr > `FMRB_REG_AUX_LO && !q_nxt.ara |=> rd_data == 8'h00)
    else $error("undefined register read not zero");

  // main scenarios
  c_alert_set: cover property (@(posedge clk) disable iff (srst) !alert_oe ##1 alert_oe);
  c_test_write: cover property (@(posedge clk) disable iff (srst)
    bus_in.wr_valid && q_r.ctrl[`FMRB_CTRL_TEST] && is_adc_reg(q_r.ptr));
  c_ara: cover property (@(posedge clk) disable iff (srst) q_r.ara && bus_in.ara_sent);
  c_alert_release: cover property (@(posedge clk) disable iff (srst)
    alert_oe && indiv_hit ##1 !alert_oe);
  c_bcast_mode: cover property (@(posedge clk) disable iff (srst)
    broadcast_mode && bus_in.addr_valid);
endmodule // fmrb_top

// ### testbench/fmrb_host_model.sv
`timescale 1ns/10ps
// behavioural bus host that hands byte events to the register bank
module fmrb_host_model (
  input wire logic clk,
  output fmrb_pkg::fmrb_bus_s bus_out
);
  import fmrb_pkg::*;
  int gap = 0;

  initial
  begin
    bus_out = '0;
  end

  // one strobe per call, data inverted once released so stale bytes never match
  task automatic strobe(input int kind, input logic [7:0] b);
    @(negedge clk);
    bus_out.addr_valid = (kind == 0);
    bus_out.cmd_valid = (kind == 1);
    bus_out.wr_valid = (kind == 2);
    bus_out.ara_sent = (kind == 3);
    bus_out.stop = (kind == 4);
    bus_out.addr_byte = b;
    bus_out.cmd = b;
    bus_out.wr_data = b;
    @(negedge clk);
    bus_out.addr_valid = 1'b0;
    bus_out.cmd_valid = 1'b0;
    bus_out.wr_valid = 1'b0;
    bus_out.ara_sent = 1'b0;
    bus_out.stop = 1'b0;
    bus_out.addr_byte = ~b;
    bus_out.cmd = ~b;
    bus_out.wr_data = ~b;
    // idle cycles model a slow host
    repeat (gap) @(negedge clk);
  endtask
endmodule // fmrb_host_model

// ### testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import fmrb_pkg::*;
  logic clk, srst, pg_ext, pg_pin, pg_o, pg_oe, al_o, al_oe, ack, bcast, halt;
  fmrb_tri_e pin_lo, pin_hi;
  fmrb_bus_s bus;
  fmrb_mon_s mon;
  fmrb_adc_s adc;
  logic [7:0] rdd, ctl;
  logic [7:0] own = 8'h20;
  int fail_count = 0;
  int cmp_count = 0;

  // pin level resolves our drive against the board side
  assign pg_pin = pg_oe ? pg_o : pg_ext;

  fmrb_top i_fmrb_top (.clk(clk), .srst(srst), .addr_select_pin_lo(pin_lo),
    .addr_select_pin_hi(pin_hi), .bus_in(bus), .mon_in(mon), .adc_in(adc),
    .power_good_gp_pin_i(pg_pin), .power_good_gp_pin_o(pg_o), .power_good_gp_pin_oe(pg_oe),
    .alert_o(al_o), .alert_oe(al_oe), .addr_ack(ack), .broadcast_mode(bcast),
    .rd_data(rdd), .control_out(ctl), .adc_halt(halt));
  fmrb_host_model i_fmrb_host_model (.clk(clk), .bus_out(bus));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic send(input int k, input logic [7:0] b);
    i_fmrb_host_model.strobe(k, b);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    send(0, a);
    send(1, p);
    send(2, d);
    send(4, 8'h00);
  endtask

  // read: pointer write then sample after the registered lag
  task automatic rdchk(input logic [7:0] p, input logic [7:0] exp, input string what);
    send(0, own);
    send(1, p);
    cyc(2);
    chk(rdd, exp, what);
    send(4, 8'h00);
  endtask

  // counts acknowledge pulses over a short window after an address byte
  task automatic ackchk(input logic [7:0] b, input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    send(0, b);
    repeat (3)
    begin
      n = n + {7'h00, ack};
      @(negedge clk);
    end
    send(4, 8'h00);
    chk(n, exp, "ack count");
  endtask

  // bounded wait on the alert pull; running out ends the run
  task automatic wait_oe(input logic exp, input int n);
    int i;
    for (i = 0; i < n && al_oe !== exp; i++)
      @(negedge clk);
    chk({7'h00, al_oe}, {7'h00, exp}, "alert pull");
    if (al_oe !== exp)
      give_verdict();
  endtask

  task automatic t_reset;
    rdchk(8'h01, 8'h00, "fault rst");
    rdchk(8'h02, 8'h00, "alert rst");
    rdchk(8'h03, 8'h03, "ctrl rst");
    chk(ctl, 8'h03, "ctrl out");
    chk({7'h00, halt}, 8'h00, "halt rst");
    chk({7'h00, al_o}, 8'h00, "alert level");
    $display("test reset done");
  endtask

  task automatic t_decode;
    logic [17:0] hv, lv;
    int i;
    hv = 18'h26520;
    lv = 18'h0A494;
    for (i = 0; i < 9; i++)
    begin
      pin_hi = fmrb_tri_e'(hv[2*i+:2]);
      pin_lo = fmrb_tri_e'(lv[2*i+:2]);
      cyc(3);
      chk({7'h00, bcast}, (i == 8) ? 8'h01 : 8'h00, "bcast");
      ackchk(8'h20 + 8'(2 * i) + 8'(i % 2), (i < 8) ? 8'h01 : 8'h00);
    end
    ackchk(8'h3E, 8'h00);
    pin_hi = FMRB_TRI_LOW;
    pin_lo = FMRB_TRI_LOW;
    cyc(3);
    ackchk(8'h3E, 8'h01);
    ackchk(8'h19, 8'h00);
    ackchk(8'h24, 8'h00);
    $display("test decode done");
  endtask

  task automatic t_pointer;
    wr(own, 8'hF3, 8'h07);
    chk(ctl, 8'h07, "hi nibble");
    send(0, own | 8'h01);
    cyc(2);
    chk(rdd, 8'h07, "sticky ptr");
    send(4, 8'h00);
    wr(8'h3E, 8'h03, 8'h0B);
    chk(ctl, 8'h0B, "mass write");
    wr(own, 8'h03, 8'h03);
    $display("test pointer done");
  endtask

  task automatic t_adc;
    adc = '{1'b1, 2'h0, 10'h2C7};
    cyc(1);
    adc.valid = 1'b0;
    i_fmrb_host_model.gap = 2;
    rdchk(8'h04, 8'hB1, "adc hi");
    rdchk(8'h05, 8'hC0, "adc lo");
    wr(own, 8'h04, 8'h5A);
    rdchk(8'h04, 8'hB1, "adc locked");
    i_fmrb_host_model.gap = 0;
    wr(own, 8'h03, 8'h23);
    chk({7'h00, halt}, 8'h01, "halt");
    wr(own, 8'h08, 8'h3C);
    wr(own, 8'h09, 8'hFF);
    adc = '{1'b1, 2'h2, 10'h000};
    cyc(1);
    adc.valid = 1'b0;
    rdchk(8'h08, 8'h3C, "test wr hi");
    rdchk(8'h09, 8'hC0, "test wr lo");
    wr(own, 8'h0A, 8'h55);
    rdchk(8'h0A, 8'h00, "undef 0A");
    rdchk(8'h0F, 8'h00, "undef 0F");
    wr(own, 8'h00, 8'hFF);
    rdchk(8'h00, 8'h00, "status ro");
    wr(own, 8'h03, 8'h03);
    $display("test adc done");
  endtask

  task automatic t_faults;
    mon.fet_on = 1'b1;
    mon.overcurrent = 1'b1;
    mon.high_line_input = 1'b1;
    cyc(3);
    rdchk(8'h00, 8'h85, "status a");
    mon = '{default: 1'b0, upper_threshold_input: 1'b1, external_fault_input_n: 1'b1};
    cyc(2);
    rdchk(8'h00, 8'h00, "status idle");
    rdchk(8'h01, 8'h05, "log kept");
    wr(own, 8'h03, 8'hC3);
    pg_ext = 1'b1;
    mon = '{default: 1'b1, fet_on: 1'b0, overcurrent: 1'b0, high_line_input: 1'b0,
      upper_threshold_input: 1'b0, lower_threshold_input: 1'b0,
      external_fault_input_n: 1'b0, pg_pull_low: 1'b0};
    cyc(3);
    rdchk(8'h00, 8'h7A, "status b");
    rdchk(8'h01, 8'hFF, "log b");
    mon = '{default: 1'b0, en_pin: 1'b1, upper_threshold_input: 1'b1,
      external_fault_input_n: 1'b1};
    pg_ext = 1'b0;
    cyc(2);
    rdchk(8'h00, 8'h10, "one thr low");
    wr(own, 8'h01, 8'h24);
    rdchk(8'h01, 8'h24, "log write");
    wr(own, 8'h01, 8'h00);
    rdchk(8'h01, 8'h00, "log clear");
    wr(own, 8'h03, 8'h03);
    $display("test faults done");
  endtask

  task automatic t_gpio;
    wr(own, 8'h02, 8'h40);
    wr(own, 8'h03, 8'h43);
    cyc(2);
    chk({6'h00, pg_oe, pg_o}, 8'h03, "gp drive");
    wr(own, 8'h02, 8'h00);
    cyc(2);
    chk({6'h00, pg_oe, pg_o}, 8'h02, "gp low");
    wr(own, 8'h03, 8'h03);
    mon.pg_pull_low = 1'b1;
    cyc(2);
    chk({6'h00, pg_oe, pg_o}, 8'h02, "pg pull");
    mon.pg_pull_low = 1'b0;
    $display("test gpio done");
  endtask

  task automatic t_alert;
    wr(own, 8'h02, 8'h04);
    mon.high_line_input = 1'b1;
    cyc(4);
    chk({7'h00, al_oe}, 8'h00, "masked");
    mon.overcurrent = 1'b1;
    wait_oe(1'b1, 4);
    mon.overcurrent = 1'b0;
    mon.high_line_input = 1'b0;
    send(0, own);
    send(4, 8'h00);
    wait_oe(1'b0, 4);
    cyc(4);
    chk({7'h00, al_oe}, 8'h00, "no rearm");
    wr(own, 8'h01, 8'h00);
    mon.overcurrent = 1'b1;
    wait_oe(1'b1, 4);
    mon.overcurrent = 1'b0;
    send(0, 8'h19);
    chk({7'h00, ack}, 8'h01, "ara ack");
    chk(rdd, own, "ara addr");
    send(3, 8'h00);
    wait_oe(1'b0, 4);
    send(4, 8'h00);
    wr(own, 8'h02, 8'h00);
    $display("test alert done");
  endtask

  // a hang anywhere ends the run as a failure
  initial
  begin
    #500us;
    fail_count++;
    $display("wrong value at %0t: run timed out", $time);
    give_verdict();
  end

  // main sequence
  initial
  begin
    srst = 1'b1;
    pg_ext = 1'b0;
    pin_lo = FMRB_TRI_LOW;
    pin_hi = FMRB_TRI_LOW;
    adc = '0;
    mon = '{default: 1'b0, upper_threshold_input: 1'b1, lower_threshold_input: 1'b1,
      external_fault_input_n: 1'b1};
    repeat (10) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    cyc(2);
    t_reset();
    t_decode();
    t_pointer();
    t_adc();
    t_faults();
    t_gpio();
    t_alert();
    give_verdict();
  end
endmodule // tb_top
